// ---- common/codec_ctrl_pkg.sv ----
// package: register indices, field positions, reset values and types of
// the codec control block.
// assumes APB byte address = 4 * register index, data in the low 16 bits.
package codec_ctrl_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_HANDSHAKE  = 16'h0600; // isp_slice_handshake
  localparam logic [15:0] IDX_CONTROL    = 16'h0A00; // codec_control
  localparam logic [15:0] IDX_RESTART    = 16'h0A02; // restart_interval_setting
  localparam logic [15:0] IDX_IRQ_CTRL   = 16'h0A04; // codec_interrupt_control
  localparam logic [15:0] IDX_FIRE       = 16'h0AAE; // go / soft reset strobes
  localparam logic [15:0] IDX_STATUS     = 16'h0AB0; // engine status, read only
  localparam logic [15:0] IDX_RING_TOTAL = 16'h0B00; // ring size and fill

  // reset values
  localparam logic [15:0] RST_HANDSHAKE  = 16'h0000; // handshake reset
  localparam logic [15:0] RST_CONTROL    = 16'h0000; // control reset
  localparam logic [15:0] RST_RESTART    = 16'h0000; // restart count reset
  localparam logic [15:0] RST_IRQ_CTRL   = 16'h0000; // interrupt control reset
  localparam logic [7:0]  RST_RING_TOTAL = 8'h10;    // ring slots after reset

  // codec_control field positions
  localparam int BIT_CHROMA_LP = 13; // chroma_lowpass_on
  localparam int BIT_LUMA_LP   = 12; // luma_lowpass_on
  localparam int BIT_AC_PICK   = 11; // ac_huffman_table_pick
  localparam int BIT_DC_PICK   = 10; // dc_huffman_table_pick
  localparam int BIT_Q_PICK    = 9;  // quant_table_pick
  localparam int COMP_HI       = 8;  // decode_component_pick msb
  localparam int COMP_LO       = 7;  // decode_component_pick lsb
  localparam int BIT_SEPARATE  = 6;  // separate_component_decode
  localparam int BIT_DIRECT    = 5;  // direct_isp_source
  localparam int BIT_EDGE      = 4;  // edge_sharpen_on
  localparam int BIT_TRIG_SRC  = 3;  // encode_trigger_source
  localparam int FMT_HI        = 2;  // chroma_subsampling_format msb
  localparam int FMT_LO        = 1;  // chroma_subsampling_format lsb
  localparam int BIT_DIRECTION = 0;  // codec_direction

  // other field positions
  localparam int THR_HI        = 15; // slice_output_threshold msb
  localparam int THR_LO        = 8;  // slice_output_threshold lsb
  localparam int BIT_GO        = 8;  // codec_go
  localparam int BIT_SOFT_RST  = 0;  // engine_soft_reset
  localparam int STAT_HI       = 4;  // engine state code msb
  localparam int STAT_LO       = 1;  // engine state code lsb

  localparam logic DIR_ENCODE = 1'b0; // codec_direction encode
  localparam logic TRIG_ISP   = 1'b0; // encode_trigger_source isp

  // chroma subsampling formats
  typedef enum logic [1:0] {
    FMT_444 = 2'h0,
    FMT_422 = 2'h1,
    FMT_420 = 2'h2,
    FMT_411 = 2'h3
  } fmt_t;

  // engine sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_ISP,
    ST_RUN
  } engine_state_t;

  // effective settings presented to the datapath
  typedef struct packed {
    logic       chroma_lp;  // chroma low-pass enable
    logic       luma_lp;    // luma low-pass enable
    logic       ac_pick;    // ac table, 1 = chrominance
    logic       dc_pick;    // dc table, 1 = chrominance
    logic       q_pick;     // quant table, 1 = chrominance
    logic [1:0] comp;       // component to decode
    logic       separate;   // non-interleaved decode
    logic       direct_isp; // encode source is isp buffer
    logic       edge_on;    // edge sharpening enable
    logic       hw_seq;     // hardware sequences the flow
    fmt_t       fmt;        // subsampling format
    logic       dir;        // 0 encode, 1 decode
  } cfg_t;

endpackage

// ---- common/slice_ring_if.sv ----
// interface: control side to slice ring counter.
// assumes one clock shared by both ends.
`timescale 1ns/1ps
interface slice_ring_if #(
  parameter int CNT_W = 8 // width of counts and pointers
) ();
  logic             wr;    // isp finished one slice
  logic             rd;    // codec consumed one slice
  logic             clr;   // empty the ring
  logic [CNT_W-1:0] total; // ring size in slices
  logic [CNT_W-1:0] thr;   // production threshold
  logic [CNT_W-1:0] count; // slices present
  logic [CNT_W-1:0] wptr;  // write pointer
  logic [CNT_W-1:0] rptr;  // read pointer
  logic             allow; // isp may produce another slice

  modport ctrl (output wr, rd, clr, total, thr, input count, wptr, rptr, allow);
  modport ring (input wr, rd, clr, total, thr, output count, wptr, rptr, allow);
endinterface

// ---- core/slice_ring.sv ----
// slice_ring: read/write pointers and fill count of the isp slice ring.
// assumes pulses on wr/rd are one cycle, same clock as the ring.
`timescale 1ns/1ps
module slice_ring
  import codec_ctrl_pkg::*;
#(
  parameter int CNT_W = 8 // width of counts and pointers
) (
  input wire logic  i_clk, // system clock
  input wire logic  i_rst, // synchronous reset, active high
  slice_ring_if.ring rif   // ring control and state
);

  // refuse widths the threshold field cannot serve
  if (CNT_W < 2 || CNT_W > 8) begin : g_chk
    $error("slice_ring: CNT_W must be 2..8");
  end

  logic [CNT_W-1:0] cnt_q, cnt_d; // slices present
  logic [CNT_W-1:0] wp_q, wp_d;   // write pointer
  logic [CNT_W-1:0] rp_q, rp_d;   // read pointer
  logic             full, empty;  // ring limits
  logic             push, pop;    // accepted moves

  // advance a pointer, wrapping at the ring size
  function automatic logic [CNT_W-1:0] wrap_inc(input logic [CNT_W-1:0] p,
                                                input logic [CNT_W-1:0] tot);
    logic [CNT_W:0] nx;
    nx = {1'b0, p} + (CNT_W+1)'(1);
    wrap_inc = (nx >= {1'b0, tot}) ? '0 : nx[CNT_W-1:0];
  endfunction

  // next pointers and count; full refuses writes, empty refuses reads
  always_comb begin
    full  = (cnt_q >= rif.total);
    empty = (cnt_q == '0);
    push  = rif.wr & ~full;
    pop   = rif.rd & ~empty;
    wp_d  = push ? wrap_inc(wp_q, rif.total) : wp_q;
    rp_d  = pop ? wrap_inc(rp_q, rif.total) : rp_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + CNT_W'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CNT_W'(1);
    end
    if (rif.clr) begin
      wp_d  = '0;
      rp_d  = '0;
      cnt_d = '0;
    end
  end

  // register ring state
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
      wp_q  <= '0;
      rp_q  <= '0;
    end else begin
      cnt_q <= cnt_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
    end
  end

  assign rif.count = cnt_q;
  assign rif.wptr  = wp_q;
  assign rif.rptr  = rp_q;
  // isp may produce while under threshold and ring not full
  assign rif.allow = (cnt_q < rif.thr) & ~full;
endmodule

// ---- core/codec_control.sv ----
// codec_control: apb register bank and sequencer of the image codec.
// assumes an apb master on I_REF_CLK; datapath and isp pulses same clock.
//
// Function
// - chroma low-pass only while bit 13 set
// - luma low-pass only while bit 12 set
// - separate decode: table picks, 0 luma, 1 chroma
// - separate decode component: 00 Y, 01 U, 10 V
// - decode interleaved at 0, separate at 1
// - encode source: sram at 0, isp buffer 1
// - edge enhancement only while bit 4 set
// - encode trigger: isp at 0, command 1
// - isp trigger: hardware sequences, else software
// - trigger source ignored while decoding
// - encode only 4:2:2, decode all four
// - direction bit: 0 encode, 1 decode
// - restart marker after each counted mcu interval
// - zero restart count inserts no marker
// - isp produces slices up to threshold
// - go bit starts selected operation
// - soft reset bit resets engine state
// - slice buffer is a pointer ring
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module codec_control
  import codec_ctrl_pkg::*;
#(
  parameter int CNT_W = 8 // slice ring count width
) (
  input  wire logic        I_REF_CLK,         // system clock, 250 MHz
  input  wire logic        I_SYS_RST,         // sync reset, active high
  input  wire logic        I_PSEL,            // apb select
  input  wire logic        I_PENABLE,         // apb access phase
  input  wire logic        I_PWRITE,          // apb write
  input  wire logic [15:0] I_PADDR,           // apb byte address
  input  wire logic [31:0] I_PWDATA,          // apb write data
  output logic      [31:0] O_PRDATA,          // apb read data
  output logic             O_PREADY,          // apb ready
  output logic             O_PSLVERR,         // apb error, unmapped
  input  wire logic        I_ISP_ENC_TRIG,    // isp encode trigger pulse
  input  wire logic        I_ENGINE_DONE,     // datapath finished pulse
  input  wire logic        I_MCU_DONE,        // one mcu encoded pulse
  input  wire logic        I_ISP_SLICE_WR,    // isp wrote one slice
  input  wire logic        I_ENC_SLICE_RD,    // codec read one slice
  output logic             O_ENGINE_START,    // start pulse to datapath
  output logic             O_ENGINE_BUSY,     // operation in progress
  output logic             O_ENGINE_SOFT_RST, // engine reset pulse
  output logic             O_RESTART_MARKER,  // insert marker pulse
  output logic             O_CHROMA_LP_ON,    // chroma low-pass enable
  output logic             O_LUMA_LP_ON,      // luma low-pass enable
  output logic             O_AC_TABLE_PICK,   // ac table chroma
  output logic             O_DC_TABLE_PICK,   // dc table chroma
  output logic             O_QUANT_TABLE_PICK,// quant table chroma
  output logic [1:0]       O_DECODE_COMP_PICK,// component to decode
  output logic             O_SEPARATE_DECODE, // non-interleaved decode
  output logic             O_DIRECT_ISP_SRC,  // encode from isp buffer
  output logic             O_EDGE_SHARPEN_ON, // edge enhancement enable
  output logic             O_HW_SEQUENCE,     // hardware runs the flow
  output logic [1:0]       O_SUBSAMPLING_FMT, // chroma format
  output logic             O_CODEC_DIRECTION, // 0 encode, 1 decode
  output logic             O_ISP_SLICE_ALLOW, // isp may produce a slice
  output logic [CNT_W-1:0] O_SLICE_COUNT      // slices in the ring
);

  if (CNT_W < 2 || CNT_W > 8) begin : g_chk
    $error("codec_control: CNT_W must be 2..8");
  end

  // byte address of a register index
  function automatic logic [15:0] reg_addr(input logic [15:0] idx);
    reg_addr = {idx[13:0], 2'b00};
  endfunction

  // state code shown in the status register
  function automatic logic [3:0] state_code(input engine_state_t s);
    case (s)
      ST_IDLE:     state_code = 4'h0;
      ST_WAIT_ISP: state_code = 4'h1;
      ST_RUN:      state_code = 4'h2;
      default:     state_code = 4'hF;
    endcase
  endfunction

  slice_ring_if #(.CNT_W(CNT_W)) ring_bus (); // ring connection

  // bus slave state
  logic [31:0] prdata_q, prdata_d;   // read data
  logic        pready_q, pready_d;   // ready, one wait state
  logic        pslverr_q, pslverr_d; // error for unmapped address
  logic        access;               // access phase seen
  logic        wr_en;                // write takes effect
  logic [31:0] rd_value;             // decoded read value
  logic        hit;                  // address maps to a register

  // register file
  logic [15:0]      hs_q, hs_d;       // isp_slice_handshake
  logic [15:0]      ctrl_q, ctrl_d;   // codec_control
  logic [15:0]      dri_q, dri_d;     // restart_interval_setting
  logic [15:0]      irqc_q, irqc_d;   // codec_interrupt_control
  logic [CNT_W-1:0] total_q, total_d; // ring_slice_total
  logic             go, srst;         // fire strobes

  // engine state
  engine_state_t state_q, state_d;    // sequencer
  logic          start_q, start_d;    // start pulse
  logic          srst_q;              // soft reset pulse
  logic [15:0]   mcu_q, mcu_d;        // mcus in current interval
  logic          marker_q, marker_d;  // restart marker pulse
  logic          enc, isp_trig;       // effective mode
  cfg_t          cfg_q, cfg_d;        // registered settings
  logic          allow_q;             // registered isp permission
  logic          busy_q;              // registered busy level

  // decode address and read value
  always_comb begin
    hit      = 1'b1;
    rd_value = 32'h00000000;
    if (I_PADDR == reg_addr(IDX_HANDSHAKE)) begin
      rd_value = {16'h0000, hs_q};
    end else if (I_PADDR == reg_addr(IDX_CONTROL)) begin
      rd_value = {16'h0000, ctrl_q};
    end else if (I_PADDR == reg_addr(IDX_RESTART)) begin
      rd_value = {16'h0000, dri_q};
    end else if (I_PADDR == reg_addr(IDX_IRQ_CTRL)) begin
      rd_value = {16'h0000, irqc_q};
    end else if (I_PADDR == reg_addr(IDX_FIRE)) begin
      rd_value = 32'h00000000; // strobes read as zero
    end else if (I_PADDR == reg_addr(IDX_STATUS)) begin
      rd_value[STAT_HI:STAT_LO]  = state_code(state_q);
      rd_value[BIT_DIRECTION]    = ctrl_q[BIT_DIRECTION];
    end else if (I_PADDR == reg_addr(IDX_RING_TOTAL)) begin
      rd_value[CNT_W-1:0]        = total_q;
      rd_value[8+CNT_W-1:8]      = ring_bus.count;
    end else begin
      hit = 1'b0; // unmapped
    end
  end

  // apb handshake: one wait state, data and error captured with ready
  always_comb begin
    access    = I_PSEL & I_PENABLE;
    wr_en     = access & pready_q & I_PWRITE;
    pready_d  = access & ~pready_q;
    prdata_d  = 32'h00000000;
    pslverr_d = 1'b0;
    if (access && !pready_q) begin
      prdata_d  = I_PWRITE ? 32'h00000000 : rd_value;
      pslverr_d = ~hit;
    end
  end

  // register writes and fire strobes
  always_comb begin
    hs_d    = hs_q;
    ctrl_d  = ctrl_q;
    dri_d   = dri_q;
    irqc_d  = irqc_q;
    total_d = total_q;
    go      = 1'b0;
    srst    = 1'b0;
    if (wr_en) begin
      if (I_PADDR == reg_addr(IDX_HANDSHAKE)) begin
        hs_d = I_PWDATA[15:0];
      end else if (I_PADDR == reg_addr(IDX_CONTROL)) begin
        ctrl_d = I_PWDATA[15:0];
      end else if (I_PADDR == reg_addr(IDX_RESTART)) begin
        dri_d = I_PWDATA[15:0];
      end else if (I_PADDR == reg_addr(IDX_IRQ_CTRL)) begin
        irqc_d = I_PWDATA[15:0];
      end else if (I_PADDR == reg_addr(IDX_FIRE)) begin
        go   = I_PWDATA[BIT_GO];
        srst = I_PWDATA[BIT_SOFT_RST];
      end else if (I_PADDR == reg_addr(IDX_RING_TOTAL)) begin
        total_d = I_PWDATA[CNT_W-1:0];
      end
    end
  end

  // register bus and register file
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      hs_q      <= RST_HANDSHAKE;
      ctrl_q    <= RST_CONTROL;
      dri_q     <= RST_RESTART;
      irqc_q    <= RST_IRQ_CTRL;
      total_q   <= RST_RING_TOTAL[CNT_W-1:0];
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      hs_q      <= hs_d;
      ctrl_q    <= ctrl_d;
      dri_q     <= dri_d;
      irqc_q    <= irqc_d;
      total_q   <= total_d;
    end
  end

  // effective mode and settings, stale fields of the other mode masked
  always_comb begin
    enc      = (ctrl_q[BIT_DIRECTION] == DIR_ENCODE);
    isp_trig = enc & (ctrl_q[BIT_TRIG_SRC] == TRIG_ISP);
    cfg_d            = '0;
    cfg_d.dir        = ctrl_q[BIT_DIRECTION];
    cfg_d.chroma_lp  = ctrl_q[BIT_CHROMA_LP];
    cfg_d.luma_lp    = ctrl_q[BIT_LUMA_LP];
    cfg_d.edge_on    = ctrl_q[BIT_EDGE];
    cfg_d.separate   = ~enc & ctrl_q[BIT_SEPARATE];
    if (cfg_d.separate) begin
      cfg_d.ac_pick  = ctrl_q[BIT_AC_PICK];
      cfg_d.dc_pick  = ctrl_q[BIT_DC_PICK];
      cfg_d.q_pick   = ctrl_q[BIT_Q_PICK];
      cfg_d.comp     = ctrl_q[COMP_HI:COMP_LO];
    end
    cfg_d.direct_isp = enc & ctrl_q[BIT_DIRECT];
    cfg_d.hw_seq     = isp_trig;
    // encode runs 4:2:2 only; decode takes any of the four
    cfg_d.fmt = enc ? FMT_422 : fmt_t'(ctrl_q[FMT_HI:FMT_LO]);
  end

  // sequencer: go starts, isp trigger waits, soft reset aborts
  always_comb begin
    state_d = state_q;
    start_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (go) begin
          if (isp_trig) begin
            state_d = ST_WAIT_ISP;
          end else begin
            state_d = ST_RUN;
            start_d = 1'b1;
          end
        end
      end
      ST_WAIT_ISP: begin
        if (I_ISP_ENC_TRIG) begin
          state_d = ST_RUN;
          start_d = 1'b1;
        end
      end
      ST_RUN: begin
        if (I_ENGINE_DONE) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (srst) begin
      state_d = ST_IDLE;
      start_d = 1'b0;
    end
  end

  // restart interval counter, encode only
  always_comb begin
    mcu_d    = mcu_q;
    marker_d = 1'b0;
    if (state_q == ST_RUN && enc && dri_q != 16'h0000 && I_MCU_DONE) begin
      if (mcu_q == dri_q - 16'h0001) begin
        mcu_d    = 16'h0000;
        marker_d = 1'b1;
      end else begin
        mcu_d = mcu_q + 16'h0001;
      end
    end
    if (srst || start_d) begin
      mcu_d    = 16'h0000;
      marker_d = 1'b0;
    end
  end

  // register engine state and output settings
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      state_q  <= ST_IDLE;
      start_q  <= 1'b0;
      srst_q   <= 1'b0;
      mcu_q    <= 16'h0000;
      marker_q <= 1'b0;
      cfg_q    <= '0;
      allow_q  <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      start_q  <= start_d;
      srst_q   <= srst;
      mcu_q    <= mcu_d;
      marker_q <= marker_d;
      cfg_q    <= cfg_d;
      allow_q  <= ring_bus.allow & ~srst;
      busy_q   <= (state_d != ST_IDLE);
    end
  end

  // ring follows isp writes and codec reads, emptied by soft reset or start
  assign ring_bus.wr    = I_ISP_SLICE_WR;
  assign ring_bus.rd    = I_ENC_SLICE_RD;
  assign ring_bus.clr   = srst | start_d;
  assign ring_bus.total = total_q;
  assign ring_bus.thr   = hs_q[THR_LO+CNT_W-1:THR_LO];

  slice_ring #(.CNT_W(CNT_W)) u_ring (
    .i_clk (I_REF_CLK),
    .i_rst (I_SYS_RST),
    .rif   (ring_bus)
  );

  assign O_PRDATA           = prdata_q;
  assign O_PREADY           = pready_q;
  assign O_PSLVERR          = pslverr_q;
  assign O_ENGINE_START     = start_q;
  assign O_ENGINE_BUSY      = busy_q;
  assign O_ENGINE_SOFT_RST  = srst_q;
  assign O_RESTART_MARKER   = marker_q;
  assign O_CHROMA_LP_ON     = cfg_q.chroma_lp;
  assign O_LUMA_LP_ON       = cfg_q.luma_lp;
  assign O_AC_TABLE_PICK    = cfg_q.ac_pick;
  assign O_DC_TABLE_PICK    = cfg_q.dc_pick;
  assign O_QUANT_TABLE_PICK = cfg_q.q_pick;
  assign O_DECODE_COMP_PICK = cfg_q.comp;
  assign O_SEPARATE_DECODE  = cfg_q.separate;
  assign O_DIRECT_ISP_SRC   = cfg_q.direct_isp;
  assign O_EDGE_SHARPEN_ON  = cfg_q.edge_on;
  assign O_HW_SEQUENCE      = cfg_q.hw_seq;
  assign O_SUBSAMPLING_FMT  = cfg_q.fmt;
  assign O_CODEC_DIRECTION  = cfg_q.dir;
  assign O_ISP_SLICE_ALLOW  = allow_q;
  assign O_SLICE_COUNT      = ring_bus.count;
endmodule

// ---- dv/codec_ctrl_props.sv ----
// checker: control outputs and engine pulses against apb writes.
// assumes the top ports of codec_control, one clock, sync reset.
`timescale 1ns/1ps
module codec_ctrl_props
  import codec_ctrl_pkg::*;
(
  input wire logic        I_REF_CLK,          // system clock
  input wire logic        I_SYS_RST,          // sync reset
  input wire logic        I_PSEL,             // apb select
  input wire logic        I_PENABLE,          // apb access
  input wire logic        I_PWRITE,           // apb write
  input wire logic [15:0] I_PADDR,            // apb address
  input wire logic [31:0] I_PWDATA,           // apb write data
  input wire logic        O_PREADY,           // apb ready
  input wire logic        O_ENGINE_BUSY,      // engine busy
  input wire logic        O_ENGINE_SOFT_RST,  // engine reset pulse
  input wire logic        O_CHROMA_LP_ON,     // chroma low-pass
  input wire logic        O_LUMA_LP_ON,       // luma low-pass
  input wire logic        O_EDGE_SHARPEN_ON,  // edge enable
  input wire logic        O_CODEC_DIRECTION,  // 0 encode
  input wire logic [1:0]  O_SUBSAMPLING_FMT,  // chroma format
  input wire logic        O_HW_SEQUENCE,      // hardware flow
  input wire logic        O_SEPARATE_DECODE,  // non-interleaved
  input wire logic        O_AC_TABLE_PICK,    // ac table pick
  input wire logic        O_DIRECT_ISP_SRC,   // isp source
  input wire logic [1:0]  O_DECODE_COMP_PICK  // component pick
);
  wire logic acc = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY; // write taken
  wire logic wce = acc && I_PADDR == (IDX_CONTROL << 2);       // control write
  wire logic wfi = acc && I_PADDR == (IDX_FIRE << 2);          // fire write
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  a_ctrl_dir_edge: assert property (wce |=> ##1 O_CODEC_DIRECTION == $past(I_PWDATA[0], 2)
    && O_EDGE_SHARPEN_ON == $past(I_PWDATA[4], 2)) else $error("dir/edge");
  a_ctrl_lowpass: assert property (wce |=> ##1 O_CHROMA_LP_ON == $past(I_PWDATA[13], 2)
    && O_LUMA_LP_ON == $past(I_PWDATA[12], 2)) else $error("lowpass");
  a_enc_fmt_fixed: assert property (wce && !I_PWDATA[0] |=> ##1 O_SUBSAMPLING_FMT == 2'h1)
    else $error("enc fmt");
  a_dec_fmt_field: assert property (wce && I_PWDATA[0] |=> ##1
    O_SUBSAMPLING_FMT == $past(I_PWDATA[2:1], 2)) else $error("dec fmt");
  a_dec_no_hwseq: assert property (O_CODEC_DIRECTION |-> !O_HW_SEQUENCE && !O_DIRECT_ISP_SRC)
    else $error("enc-only in dec");
  a_enc_no_separate: assert property (wce && !I_PWDATA[0] |=> ##1 !O_SEPARATE_DECODE
    && !O_AC_TABLE_PICK) else $error("dec-only in enc");
  a_comp_interleave: assert property (!O_SEPARATE_DECODE |-> O_DECODE_COMP_PICK == 2'h0)
    else $error("comp pick");
  a_enc_trig_src: assert property (wce && !I_PWDATA[0] |=> ##1
    O_HW_SEQUENCE == !$past(I_PWDATA[3], 2)) else $error("trig src");
  a_go_busy: assert property (wfi && I_PWDATA[8] && !I_PWDATA[0] && !O_ENGINE_BUSY
    |=> O_ENGINE_BUSY) else $error("no start");
  a_soft_rst_pulse: assert property (wfi && I_PWDATA[0] |=> O_ENGINE_SOFT_RST)
    else $error("no soft reset");
endmodule

// ---- dv/isp_model.sv ----
// isp_model: image processor side, writes slices and triggers encodes.
// assumes allow, busy and hw-sequence levels of the codec control.
`timescale 1ns/1ps
module isp_model (
  input  wire logic i_clk,         // system clock
  input  wire logic i_rst,         // sync reset
  input  wire logic i_allow,       // room under threshold
  input  wire logic i_busy,        // engine busy
  input  wire logic i_hwseq,       // hardware runs the flow
  input  wire logic i_slow,        // long gap between slices
  output logic      o_wr = 1'b0,   // one slice written
  output logic      o_trig = 1'b0  // encode trigger pulse
);
  logic [3:0] gap_q;  // cycles to next slice, covers stale allow
  logic       sent_q; // trigger already given this run
  // one slice per allow sample, one trigger per busy run
  always @(posedge i_clk) begin
    o_wr <= 1'b0;
    o_trig <= 1'b0;
    if (i_rst) begin
      gap_q <= 4'h0;
      sent_q <= 1'b0;
    end else begin
      if (gap_q != 4'h0) gap_q <= gap_q - 4'h1;
      else if (i_allow) begin
        o_wr <= 1'b1;
        gap_q <= i_slow ? 4'hA : 4'h3;
      end
      if (i_busy && i_hwseq && !sent_q) begin
        o_trig <= 1'b1;
        sent_q <= 1'b1;
      end
      if (!i_busy) sent_q <= 1'b0;
    end
  end
endmodule

// ---- dv/testbench.sv ----
// testbench: registers, settings, engine runs and slice ring over apb.
// assumes codec_control with CNT_W 8 and the isp_model partner.
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module testbench;
  import codec_ctrl_pkg::*;
  logic I_REF_CLK, I_SYS_RST, I_PSEL, I_PENABLE, I_PWRITE, I_ENGINE_DONE, I_MCU_DONE;
  logic I_ENC_SLICE_RD, I_ISP_ENC_TRIG, I_ISP_SLICE_WR, O_PREADY, O_PSLVERR, err, slow;
  logic O_ENGINE_START, O_ENGINE_BUSY, O_ENGINE_SOFT_RST, O_RESTART_MARKER, O_CHROMA_LP_ON;
  logic O_LUMA_LP_ON, O_AC_TABLE_PICK, O_DC_TABLE_PICK, O_QUANT_TABLE_PICK, O_SEPARATE_DECODE;
  logic O_DIRECT_ISP_SRC, O_EDGE_SHARPEN_ON, O_HW_SEQUENCE, O_CODEC_DIRECTION, O_ISP_SLICE_ALLOW;
  logic [1:0]  O_DECODE_COMP_PICK, O_SUBSAMPLING_FMT; // two-bit fields
  logic [7:0]  O_SLICE_COUNT;                         // ring fill
  logic [15:0] I_PADDR, c;                            // address, control word
  logic [31:0] I_PWDATA, O_PRDATA, q;                 // apb data
  logic [15:0] ra [4] = '{IDX_HANDSHAKE, IDX_CONTROL, IDX_RESTART, IDX_IRQ_CTRL};
  int mismatches = 0, total_checks = 0, n_start = 0, n_mark = 0, s0, m0, n;
  codec_control #(.CNT_W(8)) i_dut (.*);
  isp_model i_isp (.i_clk(I_REF_CLK), .i_rst(I_SYS_RST), .i_allow(O_ISP_SLICE_ALLOW),
    .i_busy(O_ENGINE_BUSY), .i_hwseq(O_HW_SEQUENCE), .i_slow(slow),
    .o_wr(I_ISP_SLICE_WR), .o_trig(I_ISP_ENC_TRIG));
  initial begin
    I_REF_CLK = 1'b0;
    forever #2 I_REF_CLK = ~I_REF_CLK;
  end
  // count start and marker pulses
  always @(posedge I_REF_CLK) begin
    if (O_ENGINE_START === 1'b1) n_start++;
    if (O_RESTART_MARKER === 1'b1) n_mark++;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task tk(input int k); repeat (k) @(posedge I_REF_CLK); endtask
  // one apb transfer, held until ready is sampled high
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    tk(1);
    {I_PSEL, I_PWRITE, I_PADDR, I_PWDATA} <= {1'b1, w, a, d};
    tk(1);
    I_PENABLE <= 1'b1;
    k = 0;
    do begin tk(1); k++; end while (O_PREADY !== 1'b1 && k < 20);
    if (k >= 20) begin mismatches++; wrap_up(); end
    q = O_PRDATA;
    err = O_PSLVERR;
    {I_PSEL, I_PENABLE} <= 2'b00;
  endtask
  task wreg(input logic [15:0] i, input logic [31:0] d); xfer(1'b1, i << 2, d); endtask
  task rreg(input logic [15:0] i); xfer(1'b0, i << 2, 32'h0); endtask
  task cfg(input logic [15:0] v); wreg(IDX_CONTROL, {16'h0, v}); tk(2); endtask
  task pulse(input logic [2:0] m);
    tk(1); {I_MCU_DONE, I_ENGINE_DONE, I_ENC_SLICE_RD} <= m;
    tk(1); {I_MCU_DONE, I_ENGINE_DONE, I_ENC_SLICE_RD} <= 3'h0;
  endtask
  initial begin
    {I_SYS_RST, I_PSEL, I_PENABLE, I_PWRITE, I_ENGINE_DONE, I_MCU_DONE} = 6'h20;
    {I_ENC_SLICE_RD, slow, I_PADDR, I_PWDATA} = '0;
    tk(4);
    I_SYS_RST <= 1'b0;
    foreach (ra[i]) begin rreg(ra[i]); `CHK("reset value", 32'h0, q) end
    rreg(IDX_RING_TOTAL); `CHK("ring reset", 32'h10, q)
    foreach (ra[i]) begin
      wreg(ra[i], 32'hFFFF_5A3C ^ i);
      rreg(ra[i]); `CHK("readback", 32'h5A3C ^ i, q)
    end
    xfer(1'b0, 16'h0004, 32'h0); `CHK("unmapped err", 1'b1, err)
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      c = {2'b00, i[0], ~i[0], i[0], i[1], i[0], i[1:0], 2'b11, i[1], 1'b0, i[1:0], 1'b1};
      cfg(c);
      `CHK("format", i[1:0], O_SUBSAMPLING_FMT)
      `CHK("picks", c[11:7], {O_AC_TABLE_PICK, O_DC_TABLE_PICK, O_QUANT_TABLE_PICK, O_DECODE_COMP_PICK})
      `CHK("sep hw src", 3'b100, {O_SEPARATE_DECODE, O_HW_SEQUENCE, O_DIRECT_ISP_SRC})
      `CHK("filters", {c[13:12], c[4], 1'b1}, {O_CHROMA_LP_ON, O_LUMA_LP_ON, O_EDGE_SHARPEN_ON, O_CODEC_DIRECTION})
    end
    cfg(16'h0F83);
    `CHK("interleaved", 6'h0, {O_SEPARATE_DECODE, O_AC_TABLE_PICK, O_DC_TABLE_PICK, O_QUANT_TABLE_PICK, O_DECODE_COMP_PICK})
    cfg(16'h0478); // isp source with edge on, command trigger
    `CHK("encode", 6'h12, {O_SUBSAMPLING_FMT, O_DC_TABLE_PICK, O_SEPARATE_DECODE, O_DIRECT_ISP_SRC, O_HW_SEQUENCE})
    cfg(16'h0030); `CHK("isp trigger", 1'b1, O_HW_SEQUENCE)
    $display("settings test done");
    wreg(IDX_RESTART, 32'h3);
    cfg(16'h0018);
    s0 = n_start;
    m0 = n_mark;
    wreg(IDX_FIRE, 32'h100);
    wreg(IDX_FIRE, 32'h100);
    tk(2);
    `CHK("one start", s0 + 1, n_start)
    repeat (7) pulse(3'h4);
    tk(3);
    `CHK("markers", m0 + 2, n_mark)
    pulse(3'h2);
    tk(2);
    `CHK("idle", 1'b0, O_ENGINE_BUSY)
    wreg(IDX_RESTART, 32'h0);
    wreg(IDX_FIRE, 32'h100);
    repeat (5) pulse(3'h4);
    pulse(3'h2);
    `CHK("no markers", m0 + 2, n_mark)
    $display("restart test done");
    wreg(IDX_HANDSHAKE, 32'h0400);
    cfg(16'h0030);
    s0 = n_start;
    wreg(IDX_FIRE, 32'h100);
    for (n = 0; n < 50 && n_start == s0; n++) tk(1);
    `CHK("isp start", s0 + 1, n_start)
    for (n = 0; n < 300 && O_SLICE_COUNT !== 8'h4; n++) tk(1);
    slow <= 1'b1;
    repeat (2) pulse(3'h1);
    tk(60);
    `CHK("threshold", 8'h4, O_SLICE_COUNT)
    rreg(IDX_RING_TOTAL); `CHK("ring reg", 32'h0410, q)
    wreg(IDX_FIRE, 32'h1);
    rreg(IDX_STATUS); `CHK("soft reset", 32'h0, q)
    $display("engine test done");
    wrap_up();
  end
  initial begin
    #200000 mismatches++;
    wrap_up();
  end
endmodule
bind codec_control codec_ctrl_props u_props (.*);
